// ---- ulm_baud_generator.sv ----
`timescale 1ns/1ps
module ulm_baud_generator #(
  parameter int WIDTH = 16
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] divisor,
  output logic                  tick
);
  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] cnt_next;
  logic             tick_reg;
  logic             tick_next;
  logic             wrap;

  // Divisor zero behaves like one
  always_comb begin
    wrap      = (divisor == '0) || (cnt_reg >= divisor - 1'b1);
    cnt_next  = wrap ? '0 : cnt_reg + 1'b1;
    tick_next = wrap;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;
endmodule // ulm_baud_generator

// ---- ulm_pkg.sv ----
package ulm_pkg;
  // Register indices; byte address is four times the index
  localparam logic [13:0] IDX_DATA      = 14'h0f40;
  localparam logic [13:0] IDX_STATUS    = 14'h0f41;
  localparam logic [13:0] IDX_LINE_CTL  = 14'h0f42;
  localparam logic [13:0] IDX_MODE_CTL  = 14'h0f43;
  localparam logic [13:0] IDX_ADDR_CMP  = 14'h0f44;
  localparam logic [13:0] IDX_BAUD_HI   = 14'h0f46;
  localparam logic [13:0] IDX_BAUD_LO   = 14'h0f47;

  // serial_line_control fields
  localparam int LC_TX_EN    = 7;
  localparam int LC_RX_EN    = 6;
  localparam int LC_CTS_GATE = 5;
  localparam int LC_PAR_EN   = 4;
  localparam int LC_PAR_ODD  = 3;
  localparam int LC_BREAK    = 2;
  localparam int LC_STOP2    = 1;
  localparam int LC_LOOP     = 0;

  // serial_mode_control fields
  localparam int MC_SCHEME_HI = 7;
  localparam int MC_MP_EN     = 6;
  localparam int MC_SCHEME_LO = 5;
  localparam int MC_MP_TX_BIT = 4;
  localparam int MC_DE_POL    = 3;

  localparam logic [7:0]  LINE_CTL_RST = 8'h00;
  localparam logic [7:0]  MODE_CTL_RST = 8'h00;
  localparam logic [7:0]  ADDR_CMP_RST = 8'h00;
  localparam logic [15:0] BAUD_RST     = 16'h0000;

  // Oversampling: last of 16 ticks per bit and the tick that hits mid start bit
  localparam logic [3:0] SUB_LAST  = 4'hf;
  localparam logic [3:0] SUB_MID   = 4'h7;
  localparam logic [2:0] DATA_LAST = 3'h7;

  localparam logic [1:0] SCHEME_ALL       = 2'h0;
  localparam logic [1:0] SCHEME_DATA      = 2'h1;
  localparam logic [1:0] SCHEME_MATCH_RUN = 2'h2;
  localparam logic [1:0] SCHEME_MATCH_DAT = 2'h3;

  typedef enum logic [4:0] {
    TX_IDLE  = 5'b00001,
    TX_START = 5'b00010,
    TX_DATA  = 5'b00100,
    TX_EXTRA = 5'b01000,
    TX_STOP  = 5'b10000
  } ulm_tx_st_t;

  typedef enum logic [4:0] {
    RX_IDLE  = 5'b00001,
    RX_START = 5'b00010,
    RX_DATA  = 5'b00100,
    RX_EXTRA = 5'b01000,
    RX_STOP  = 5'b10000
  } ulm_rx_st_t;
endpackage

// ---- ulm_serial_station.sv ----
`timescale 1ns/1ps
module ulm_serial_station #(
  parameter int BIT_CYC = 16
) (
  input  wire logic pclk,
  input  wire logic txd,
  output logic      rxd
);
  logic [8:0] got_word = 9'h000;
  int         n_bits = 8;
  int         n_got = 0;
  int         cyc = 0;
  int         t0 = 0;
  int         per = 0;

  // Pulled-up line idles high
  initial rxd = 1'b1;

  always @(posedge pclk) begin
    cyc <= cyc + 1;
  end

  always begin
    @(negedge txd);
    per = cyc - t0;
    t0 = cyc;
    got_word = 9'h000;
    repeat (BIT_CYC / 2) @(posedge pclk);
    for (int i = 0; i < n_bits; i++) begin
      repeat (BIT_CYC) @(posedge pclk);
      got_word[i] = txd;
    end
    repeat (BIT_CYC) @(posedge pclk);
    if (txd === 1'b1) begin
      n_got++;
    end
  end

  task automatic send(input logic [8:0] w, input int nb);
    rxd <= 1'b0;
    repeat (BIT_CYC) @(posedge pclk);
    for (int i = 0; i < nb; i++) begin
      rxd <= w[i];
      repeat (BIT_CYC) @(posedge pclk);
    end
    rxd <= 1'b1;
    repeat (2 * BIT_CYC) @(posedge pclk);
  endtask
endmodule // ulm_serial_station

// ---- ulm_uart_line_and_mode_control.sv ----
// Local design decision: the APB slave port.
`timescale 1ns/1ps
module ulm_uart_line_and_mode_control #(
  parameter int BAUD_WIDTH = 16
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxd,
  input  wire logic        cts_n,
  output logic             txd,
  output logic             driver_enable_out,
  output logic             tx_irq_req,
  output logic             rx_irq_req
);
  // Bus and configuration state
  logic [31:0] prdata_reg, prdata_next;
  logic        pready_reg, pready_next;
  logic        pslverr_reg, pslverr_next;
  logic [7:0]  line_reg, line_next;
  logic [7:0]  mode_reg, mode_next;
  logic [7:0]  acmp_reg, acmp_next;
  logic [15:0] baud_reg, baud_next;
  logic [13:0] idx;
  logic        mapped, wr_acc, rd_data_acc;
  logic        baud_tick;

  assign idx    = paddr[15:2];
  assign mapped = (paddr[1:0] == 2'h0) && (idx == ulm_pkg::IDX_DATA || idx == ulm_pkg::IDX_STATUS ||
                  idx == ulm_pkg::IDX_LINE_CTL || idx == ulm_pkg::IDX_MODE_CTL ||
                  idx == ulm_pkg::IDX_ADDR_CMP || idx == ulm_pkg::IDX_BAUD_HI || idx == ulm_pkg::IDX_BAUD_LO);
  assign wr_acc      = psel && penable && pready_reg && pwrite && mapped;
  assign rd_data_acc = psel && penable && pready_reg && !pwrite && mapped && idx == ulm_pkg::IDX_DATA;

  // Configuration decode
  logic       tx_en, rx_en, cts_gate, par_en, par_odd, brk, stop2, loop_en;
  logic       mp_en, mp_tx_bit, de_pol;
  logic [1:0] scheme;
  assign tx_en     = line_reg[ulm_pkg::LC_TX_EN];
  assign rx_en     = line_reg[ulm_pkg::LC_RX_EN];
  assign cts_gate  = line_reg[ulm_pkg::LC_CTS_GATE];
  assign par_en    = line_reg[ulm_pkg::LC_PAR_EN];
  assign par_odd   = line_reg[ulm_pkg::LC_PAR_ODD];
  assign brk       = line_reg[ulm_pkg::LC_BREAK];
  assign stop2     = line_reg[ulm_pkg::LC_STOP2];
  assign loop_en   = line_reg[ulm_pkg::LC_LOOP];
  assign mp_en     = mode_reg[ulm_pkg::MC_MP_EN];
  assign mp_tx_bit = mode_reg[ulm_pkg::MC_MP_TX_BIT];
  assign de_pol    = mode_reg[ulm_pkg::MC_DE_POL];
  assign scheme    = {mode_reg[ulm_pkg::MC_SCHEME_HI], mode_reg[ulm_pkg::MC_SCHEME_LO]};

  // Transmit and receive state
  ulm_pkg::ulm_tx_st_t tx_st_reg, tx_st_next;
  ulm_pkg::ulm_rx_st_t rx_st_reg, rx_st_next;
  logic [7:0] hold_reg, hold_next, tsh_reg, tsh_next;
  logic       hfull_reg, hfull_next, tb9_reg, tb9_next, tstop_reg, tstop_next;
  logic [3:0] tsub_reg, tsub_next, rsub_reg, rsub_next;
  logic [2:0] tcnt_reg, tcnt_next, rcnt_reg, rcnt_next;
  logic       txd_reg, txd_next, de_reg, de_next, txirq_reg, txirq_next;
  logic [7:0] rsh_reg, rsh_next, rdat_reg, rdat_next;
  logic       rb9_reg, rb9_next, rdb9_reg, rdb9_next, rda_reg, rda_next;
  logic       ovr_reg, ovr_next, perr_reg, perr_next, ferr_reg, ferr_next;
  logic       match_reg, match_next, rxirq_reg, rxirq_next;
  logic       tx_gate, tx_load, tx_bit_end, rx_in, rx_sample, rx_done, is_addr, match_now, qualify;

  // Status word for reads
  logic [7:0] status;
  assign status = {rdb9_reg, 1'b0, ferr_reg, perr_reg, ovr_reg, tx_st_reg != ulm_pkg::TX_IDLE, !hfull_reg, rda_reg};

  // Bus slave: read data latched in setup, answered with pready in access
  always_comb begin
    prdata_next  = prdata_reg;
    pready_next  = 1'b0;
    pslverr_next = 1'b0;
    line_next    = line_reg;
    mode_next    = mode_reg;
    acmp_next    = acmp_reg;
    baud_next    = baud_reg;
    if (psel && !penable) begin
      pready_next  = 1'b1;
      pslverr_next = !mapped;
      prdata_next  = 32'h0000_0000;
      if (!pwrite && mapped) begin
        case (idx)
          ulm_pkg::IDX_DATA:     prdata_next[7:0] = rdat_reg;
          ulm_pkg::IDX_STATUS:   prdata_next[7:0] = status;
          ulm_pkg::IDX_LINE_CTL: prdata_next[7:0] = line_reg;
          ulm_pkg::IDX_MODE_CTL: prdata_next[7:0] = mode_reg;
          ulm_pkg::IDX_ADDR_CMP: prdata_next[7:0] = acmp_reg;
          ulm_pkg::IDX_BAUD_HI:  prdata_next[7:0] = baud_reg[15:8];
          ulm_pkg::IDX_BAUD_LO:  prdata_next[7:0] = baud_reg[7:0];
          default:               prdata_next = 32'h0000_0000;
        endcase
      end
    end
    if (wr_acc) begin
      case (idx)
        ulm_pkg::IDX_LINE_CTL: line_next = pwdata[7:0];
        ulm_pkg::IDX_MODE_CTL: mode_next = pwdata[7:0];
        ulm_pkg::IDX_ADDR_CMP: acmp_next = pwdata[7:0];
        ulm_pkg::IDX_BAUD_HI:  baud_next[15:8] = pwdata[7:0];
        ulm_pkg::IDX_BAUD_LO:  baud_next[7:0] = pwdata[7:0];
        default:               baud_next = baud_reg;
      endcase
    end
  end

  ulm_baud_generator #(.WIDTH(BAUD_WIDTH)) u_baud_generator (
    .pclk    (pclk),
    .presetn (presetn),
    .divisor (baud_reg[BAUD_WIDTH-1:0]),
    .tick    (baud_tick)
  );

  assign tx_gate    = tx_en && (!cts_gate || !cts_n);
  assign tx_load    = (tx_st_reg == ulm_pkg::TX_IDLE) && tx_gate && hfull_reg && !brk;
  assign tx_bit_end = baud_tick && (tsub_reg == ulm_pkg::SUB_LAST);

  // Transmitter
  always_comb begin
    tx_st_next = tx_st_reg;
    hold_next  = hold_reg;
    hfull_next = hfull_reg;
    tsh_next   = tsh_reg;
    tb9_next   = tb9_reg;
    tstop_next = tstop_reg;
    tcnt_next  = tcnt_reg;
    tsub_next  = baud_tick ? tsub_reg + 4'h1 : tsub_reg;
    txd_next   = 1'b1;
    if (tx_load) begin
      hfull_next = 1'b0;
      tsh_next   = hold_reg;
      tb9_next   = mp_en ? mp_tx_bit : (^hold_reg) ^ par_odd;
      tstop_next = stop2;
      tcnt_next  = 3'h0;
      tsub_next  = 4'h0;
      tx_st_next = ulm_pkg::TX_START;
    end
    if (wr_acc && idx == ulm_pkg::IDX_DATA) begin
      hold_next  = pwdata[7:0];
      hfull_next = 1'b1;
    end
    case (tx_st_reg)
      ulm_pkg::TX_IDLE:  txd_next = 1'b1;
      ulm_pkg::TX_START: begin
        txd_next = 1'b0;
        if (tx_bit_end) tx_st_next = ulm_pkg::TX_DATA;
      end
      ulm_pkg::TX_DATA: begin
        txd_next = tsh_reg[0];
        if (tx_bit_end) begin
          tsh_next  = {1'b0, tsh_reg[7:1]};
          tcnt_next = tcnt_reg + 3'h1;
          if (tcnt_reg == ulm_pkg::DATA_LAST) tx_st_next = (mp_en || par_en) ? ulm_pkg::TX_EXTRA : ulm_pkg::TX_STOP;
        end
      end
      ulm_pkg::TX_EXTRA: begin
        txd_next = tb9_reg;
        if (tx_bit_end) tx_st_next = ulm_pkg::TX_STOP;
      end
      ulm_pkg::TX_STOP: begin
        txd_next = 1'b1;
        if (tx_bit_end) begin
          tstop_next = 1'b0;
          if (!tstop_reg) tx_st_next = ulm_pkg::TX_IDLE;
        end
      end
      default: tx_st_next = ulm_pkg::TX_IDLE;
    endcase
    // break aborts frame and holds line low
    if (brk) begin
      tx_st_next = ulm_pkg::TX_IDLE;
      txd_next   = 1'b0;
    end
    de_next    = (tx_st_next != ulm_pkg::TX_IDLE) ^ de_pol;
    // transmit request while transmitter enabled and holding register empty
    txirq_next = tx_en && !hfull_next;
  end

  assign rx_in     = loop_en ? txd_reg : rxd;
  assign rx_sample = baud_tick && (rsub_reg == ulm_pkg::SUB_LAST);
  assign rx_done   = (rx_st_reg == ulm_pkg::RX_STOP) && rx_sample;
  assign is_addr   = mp_en && rb9_reg;
  assign match_now = (rsh_reg == acmp_reg);

  // Interrupt qualification per multiprocessor scheme
  always_comb begin
    qualify = 1'b1;
    if (mp_en) begin
      case (scheme)
        ulm_pkg::SCHEME_ALL:       qualify = 1'b1;
        ulm_pkg::SCHEME_DATA:      qualify = !is_addr;
        ulm_pkg::SCHEME_MATCH_RUN: qualify = is_addr ? match_now : match_reg;
        ulm_pkg::SCHEME_MATCH_DAT: qualify = !is_addr && match_reg;
        default:                   qualify = 1'b1;
      endcase
    end
  end

  // Receiver; set of each flag wins over a read clear
  always_comb begin
    rx_st_next = rx_st_reg;
    rsh_next   = rsh_reg;
    rb9_next   = rb9_reg;
    rcnt_next  = rcnt_reg;
    rsub_next  = baud_tick ? rsub_reg + 4'h1 : rsub_reg;
    rdat_next  = rdat_reg;
    rdb9_next  = rdb9_reg;
    match_next = match_reg;
    rda_next   = rd_data_acc ? 1'b0 : rda_reg;
    ovr_next   = rd_data_acc ? 1'b0 : ovr_reg;
    perr_next  = rd_data_acc ? 1'b0 : perr_reg;
    ferr_next  = rd_data_acc ? 1'b0 : ferr_reg;
    rxirq_next = rd_data_acc ? 1'b0 : rxirq_reg;
    case (rx_st_reg)
      ulm_pkg::RX_IDLE: if (!rx_in) begin
        rx_st_next = ulm_pkg::RX_START;
        rsub_next  = 4'h0;
      end
      ulm_pkg::RX_START: if (baud_tick && rsub_reg == ulm_pkg::SUB_MID) begin
        rx_st_next = rx_in ? ulm_pkg::RX_IDLE : ulm_pkg::RX_DATA;
        rsub_next  = 4'h0;
        rcnt_next  = 3'h0;
      end
      ulm_pkg::RX_DATA: if (rx_sample) begin
        rsh_next  = {rx_in, rsh_reg[7:1]};
        rcnt_next = rcnt_reg + 3'h1;
        rb9_next  = 1'b0;
        if (rcnt_reg == ulm_pkg::DATA_LAST) rx_st_next = (mp_en || par_en) ? ulm_pkg::RX_EXTRA : ulm_pkg::RX_STOP;
      end
      ulm_pkg::RX_EXTRA: if (rx_sample) begin
        rb9_next   = rx_in;
        rx_st_next = ulm_pkg::RX_STOP;
      end
      ulm_pkg::RX_STOP: if (rx_sample) begin
        rx_st_next = ulm_pkg::RX_IDLE;
        rdat_next  = rsh_reg;
        rdb9_next  = rb9_reg;
        rda_next   = 1'b1;
        ovr_next   = ovr_next || (rda_reg && !rd_data_acc);
        if (par_en && !mp_en) perr_next = perr_next || (rb9_reg != ((^rsh_reg) ^ par_odd));
        ferr_next  = ferr_next || !rx_in;
        if (is_addr) match_next = match_now;
        if (qualify) rxirq_next = 1'b1;
      end
      default: rx_st_next = ulm_pkg::RX_IDLE;
    endcase
    if (!rx_en) rx_st_next = ulm_pkg::RX_IDLE;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      line_reg   <= ulm_pkg::LINE_CTL_RST;
      mode_reg   <= ulm_pkg::MODE_CTL_RST;
      acmp_reg   <= ulm_pkg::ADDR_CMP_RST;
      baud_reg   <= ulm_pkg::BAUD_RST;
    end else begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      line_reg   <= line_next;
      mode_reg   <= mode_next;
      acmp_reg   <= acmp_next;
      baud_reg   <= baud_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_reg <= ulm_pkg::TX_IDLE;
      hold_reg  <= 8'h00;
      hfull_reg <= 1'b0;
      tsh_reg   <= 8'h00;
      tb9_reg   <= 1'b0;
      tstop_reg <= 1'b0;
      tcnt_reg  <= 3'h0;
      tsub_reg  <= 4'h0;
      txd_reg   <= 1'b1;
      de_reg    <= 1'b0;
      txirq_reg <= 1'b0;
      rx_st_reg <= ulm_pkg::RX_IDLE;
      rsh_reg   <= 8'h00;
      rb9_reg   <= 1'b0;
      rcnt_reg  <= 3'h0;
      rsub_reg  <= 4'h0;
      rdat_reg  <= 8'h00;
      rdb9_reg  <= 1'b0;
      match_reg <= 1'b0;
      rda_reg   <= 1'b0;
      ovr_reg   <= 1'b0;
      perr_reg  <= 1'b0;
      ferr_reg  <= 1'b0;
      rxirq_reg <= 1'b0;
    end else begin
      tx_st_reg <= tx_st_next;
      hold_reg  <= hold_next;
      hfull_reg <= hfull_next;
      tsh_reg   <= tsh_next;
      tb9_reg   <= tb9_next;
      tstop_reg <= tstop_next;
      tcnt_reg  <= tcnt_next;
      tsub_reg  <= tsub_next;
      txd_reg   <= txd_next;
      de_reg    <= de_next;
      txirq_reg <= txirq_next;
      rx_st_reg <= rx_st_next;
      rsh_reg   <= rsh_next;
      rb9_reg   <= rb9_next;
      rcnt_reg  <= rcnt_next;
      rsub_reg  <= rsub_next;
      rdat_reg  <= rdat_next;
      rdb9_reg  <= rdb9_next;
      match_reg <= match_next;
      rda_reg   <= rda_next;
      ovr_reg   <= ovr_next;
      perr_reg  <= perr_next;
      ferr_reg  <= ferr_next;
      rxirq_reg <= rxirq_next;
    end
  end

  assign prdata            = prdata_reg;
  assign pready            = pready_reg;
  assign pslverr           = pslverr_reg;
  assign txd               = txd_reg;
  assign driver_enable_out = de_reg;
  assign tx_irq_req        = txirq_reg;
  assign rx_irq_req        = rxirq_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_load;
    tx_load && !brk && !(wr_acc && idx == ulm_pkg::IDX_DATA);
  endsequence
  sequence s_start_out;
    (tx_st_reg == ulm_pkg::TX_START && !hfull_reg) ##1 !txd_reg;
  endsequence

  a_load_to_start: assert property (s_load |=> s_start_out) else $error("byte not loaded and started");
  a_tx_req_empty: assert property (tx_en && !hfull_reg && !(wr_acc && idx == ulm_pkg::IDX_DATA) |=> tx_irq_req)
    else $error("transmit request missing");
  a_cts_holds_tx: assert property (tx_st_reg == ulm_pkg::TX_IDLE && cts_gate && cts_n |=> tx_st_reg == ulm_pkg::TX_IDLE)
    else $error("transmitter started with clear-to-send high");
  a_break_low: assert property (brk |=> !txd_reg && tx_st_reg == ulm_pkg::TX_IDLE) else $error("break not forced");
  a_rda_after_rx: assert property (rx_done && rx_en |=> rda_reg ##1 (rda_reg || $past(rd_data_acc)))
    else $error("received byte not flagged");
  a_rda_read_clear: assert property (rd_data_acc && !rx_done |=> !rda_reg) else $error("flag not cleared by read");
  a_rx_off_idle: assert property (!rx_en |=> rx_st_reg == ulm_pkg::RX_IDLE) else $error("receiver active while off");
  a_de_polarity: assert property (tx_st_reg == ulm_pkg::TX_DATA && !brk |=> driver_enable_out == !$past(de_pol))
    else $error("driver enable polarity wrong");
  a_ninth_bit: assert property (s_load |=> tb9_reg == ($past(mp_en) ? $past(mp_tx_bit) : (^$past(hold_reg)) ^ $past(par_odd)))
    else $error("ninth bit wrong");
  a_loop_start: assert property (loop_en && rx_en && rx_st_reg == ulm_pkg::RX_IDLE && !txd_reg |=> rx_st_reg == ulm_pkg::RX_START)
    else $error("loopback not seen by receiver");
  a_stop_two: assert property (tx_st_reg == ulm_pkg::TX_STOP && tstop_reg && tx_bit_end && !brk |=> tx_st_reg == ulm_pkg::TX_STOP)
    else $error("second stop bit missing");
endmodule // ulm_uart_line_and_mode_control

// ---- ulm_uart_line_and_mode_control_tb.sv ----
`timescale 1ns/1ps
module ulm_uart_line_and_mode_control_tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        cts_n = 1'b1;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rxd;
  logic        txd;
  logic        drv_en;
  logic        tx_irq;
  logic        rx_irq;
  logic [31:0] rv;
  logic        err;
  logic        de_mid;
  int          n_fail = 0;
  int          checks = 0;
  int          p1;
  int          n0;
  logic [7:0]  lc_t[4] = '{8'hd0, 8'hd8, 8'hc0, 8'hc0};
  logic [7:0]  mc_t[4] = '{8'h00, 8'h00, 8'h40, 8'h50};
  logic [8:0]  ex_t[4] = '{9'h137, 9'h037, 9'h037, 9'h137};

  always #2.5 pclk = ~pclk;

  ulm_uart_line_and_mode_control i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd(rxd), .cts_n(cts_n), .txd(txd), .driver_enable_out(drv_en),
    .tx_irq_req(tx_irq), .rx_irq_req(rx_irq)
  );
  ulm_serial_station #(.BIT_CYC(16)) i_peer (.pclk(pclk), .txd(txd), .rxd(rxd));

  task automatic results;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic hang;
    n_fail++;
    results();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [13:0] idx, input logic [7:0] d, output logic [31:0] r);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    // Registered answer is settled mid-cycle and holds to the next rising edge
    do begin
      @(negedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      hang();
    end
    r = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [13:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d, rv);
  endtask

  task automatic rchk(input logic [13:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00, rv);
    chk(rv, exp);
  endtask

  // Port is disabled before any reconfiguration
  task automatic cfg(input logic [7:0] lc, input logic [7:0] mc);
    wr(ulm_pkg::IDX_LINE_CTL, 8'h00);
    wr(ulm_pkg::IDX_MODE_CTL, mc);
    wr(ulm_pkg::IDX_LINE_CTL, lc);
  endtask

  task automatic wait_n(input int target);
    for (int k = 0; k < 5000 && i_peer.n_got < target; k++) @(posedge pclk);
    if (i_peer.n_got < target) begin
      hang();
    end
  endtask

  task automatic tx_chk(input logic [7:0] b, input logic [8:0] exp);
    int n;
    n = i_peer.n_got;
    wr(ulm_pkg::IDX_DATA, b);
    repeat (30) @(posedge pclk);
    de_mid = drv_en;
    wait_n(n + 1);
    chk(32'(i_peer.got_word), 32'(exp));
  endtask

  task automatic tx_pair;
    int n;
    n = i_peer.n_got;
    wr(ulm_pkg::IDX_DATA, 8'h55);
    wr(ulm_pkg::IDX_DATA, 8'h0f);
    wait_n(n + 2);
  endtask

  task automatic rx_chk(input logic [7:0] exp);
    int k;
    k = 0;
    do begin
      apb(1'b0, ulm_pkg::IDX_STATUS, 8'h00, rv);
      k++;
    end while (rv[0] !== 1'b1 && k < 400);
    if (rv[0] !== 1'b1) begin
      hang();
    end
    rchk(ulm_pkg::IDX_DATA, 32'(exp));
    apb(1'b0, ulm_pkg::IDX_STATUS, 8'h00, rv);
    chk(32'(rv[0]), 32'h0);
  endtask

  task automatic irq_chk(input logic [8:0] w, input logic exp);
    i_peer.send(w, 9);
    chk(32'(rx_irq), 32'(exp));
    apb(1'b0, ulm_pkg::IDX_DATA, 8'h00, rv);
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(ulm_pkg::IDX_LINE_CTL, 32'h0000_0000);
    rchk(ulm_pkg::IDX_MODE_CTL, 32'h0000_0000);
    apb(1'b0, 14'h0f45, 8'h00, rv);
    chk(32'(err), 32'h1);
    chk(32'(tx_irq), 32'h0);
    chk(32'(drv_en), 32'h0);
    wr(ulm_pkg::IDX_BAUD_LO, 8'h01);
    cfg(8'hc0, 8'h00);
    repeat (2) @(posedge pclk);
    chk(32'(tx_irq), 32'h1);
    tx_chk(8'ha5, 9'h0a5);
    chk(32'(de_mid), 32'h1);
    i_peer.n_bits = 9;
    for (int i = 0; i < 4; i++) begin
      cfg(lc_t[i], mc_t[i]);
      tx_chk(8'h37, ex_t[i]);
    end
    i_peer.n_bits = 8;
    cfg(8'h80, 8'h00);
    tx_pair();
    p1 = i_peer.per;
    cfg(8'h82, 8'h00);
    tx_pair();
    chk(32'(i_peer.per - p1), 32'h10);
    cfg(8'hc1, 8'h00);
    wr(ulm_pkg::IDX_DATA, 8'h3c);
    rx_chk(8'h3c);
    cfg(8'h40, 8'h00);
    i_peer.send(9'h05a, 8);
    rx_chk(8'h5a);
    cfg(8'h80, 8'h00);
    i_peer.send(9'h0c3, 8);
    apb(1'b0, ulm_pkg::IDX_STATUS, 8'h00, rv);
    chk(32'(rv[0]), 32'h0);
    cfg(8'h40, 8'he0);
    wr(ulm_pkg::IDX_ADDR_CMP, 8'h12);
    irq_chk(9'h112, 1'b0);
    irq_chk(9'h077, 1'b1);
    irq_chk(9'h113, 1'b0);
    irq_chk(9'h044, 1'b0);
    cfg(8'h40, 8'h40);
    irq_chk(9'h113, 1'b1);
    cfg(8'ha0, 8'h00);
    n0 = i_peer.n_got;
    wr(ulm_pkg::IDX_DATA, 8'h81);
    repeat (300) @(posedge pclk);
    chk(32'(i_peer.n_got - n0), 32'h0);
    chk(32'(tx_irq), 32'h0);
    cts_n <= 1'b0;
    wait_n(n0 + 1);
    chk(32'(i_peer.got_word), 32'h81);
    cfg(8'h80, 8'h08);
    repeat (20) @(posedge pclk);
    chk(32'(drv_en), 32'h1);
    cfg(8'h84, 8'h08);
    repeat (2) @(posedge pclk);
    chk(32'(txd), 32'h0);
    results();
  end
endmodule // ulm_uart_line_and_mode_control_tb
